/* File: hw/fcw_host.v */
/*
 Host-side controller for a byte-wide, sixteen-block flash memory.
 Software sets address, data and an operation through a small register
 port; the controller issues the write-strobe command cycles on the pins
 and watches ready_busy_n. Assumes pins are synchronous to core_clk.
*/
//
// Function
// - Start operations only by command sequences
// - Three lock configuration commands issued by host
// - Wait wake time after power-down release
// - No writes below 3.0V core supply
`timescale 1ns/1ps
`include "fcw_map.vh"

module fcw_host #(
   parameter ADDR_W = `FCW_ADDR_W,
   parameter WAKE_CYC = `FCW_WAKE_CYC
) (
   input wire core_clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg [ADDR_W-1:0] flash_addr,
   input wire [7:0] flash_dq_in,
   output reg [7:0] flash_dq_out,
   output reg flash_dq_oe,
   output reg chip_select_n,
   output reg output_enable_n,
   output reg write_strobe_n,
   output reg reset_powerdown_n,
   output reg hv_override,
   input wire ready_busy_n,
   input wire supply_ok
);

   localparam S_IDLE = 3'd0;
   localparam S_LOW = 3'd1;
   localparam S_HIGH = 3'd2;
   localparam S_WAIT = 3'd3;
   localparam S_RDLOW = 3'd4;
   localparam S_WAKE = 3'd5;

   reg [2:0] state_q;
   reg [2:0] op_q;
   reg [ADDR_W-1:0] addr_q;
   reg [7:0] data_q;
   reg [7:0] rdat_q;
   reg second_q;
   reg done_q;
   reg susp_q;
   reg refused_q;
   reg pwrdn_q;
   reg [15:0] cnt_q;
   reg [7:0] cyc_data;
   reg [ADDR_W-1:0] cyc_addr;
   reg two_cycle;
   wire [2:0] op_w = reg_wdata[`FCW_CTRL_OP_MSB:`FCW_CTRL_OP_LSB];
   wire busy = (state_q != S_IDLE);
   wire go = reg_wr && (reg_addr == `FCW_REG_CTRL) && reg_wdata[`FCW_CTRL_GO];
   // suspend is the only command taken while busy
   wire may_go = (!busy && ready_busy_n) || (op_w == `FCW_OP_SUSPEND && state_q == S_WAIT);

   // ----------------------------------------
   // Command cycle selection
   // ----------------------------------------
   always @* begin
      cyc_addr = addr_q;
      two_cycle = 1'b0;
      cyc_data = `FCW_CMD_READ;
      case (op_q)
         `FCW_OP_ERASE: begin
            // one block, second cycle on its address
            cyc_data = second_q ? `FCW_CMD_CONFIRM : `FCW_CMD_ERASE1;
            two_cycle = 1'b1;
         end
         `FCW_OP_WRITE: begin
            cyc_data = second_q ? data_q : `FCW_CMD_WRITE;
            two_cycle = 1'b1;
         end
         `FCW_OP_SETLOCK: begin
            // lock set, master set, clear all
            cyc_data = second_q ? `FCW_CMD_SETLOCK : `FCW_CMD_LOCK;
            two_cycle = 1'b1;
         end
         `FCW_OP_SETMASTER: begin
            cyc_data = second_q ? `FCW_CMD_SETMASTER : `FCW_CMD_LOCK;
            two_cycle = 1'b1;
         end
         `FCW_OP_CLRLOCK: begin
            cyc_data = second_q ? `FCW_CMD_CONFIRM : `FCW_CMD_LOCK;
            two_cycle = 1'b1;
         end
         `FCW_OP_SUSPEND: cyc_data = `FCW_CMD_SUSPEND;
         `FCW_OP_RESUME: cyc_data = `FCW_CMD_CONFIRM;
         default: cyc_data = `FCW_CMD_READ;
      endcase
   end

   // ----------------------------------------
   // Pin sequencer
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= S_WAKE;
         op_q <= `FCW_OP_READ;
         addr_q <= {ADDR_W{1'b0}};
         data_q <= 8'h00;
         rdat_q <= 8'h00;
         second_q <= 1'b0;
         done_q <= 1'b0;
         susp_q <= 1'b0;
         refused_q <= 1'b0;
         pwrdn_q <= 1'b0;
         hv_override <= 1'b0;
         cnt_q <= 16'h0000;
         flash_addr <= {ADDR_W{1'b0}};
         flash_dq_out <= 8'h00;
         flash_dq_oe <= 1'b0;
         chip_select_n <= 1'b1;
         output_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         reset_powerdown_n <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `FCW_REG_ADDR: reg_rdata <= {4'h0, addr_q[`FCW_BLK_LSB+3:`FCW_BLK_LSB]};
               `FCW_REG_DATA: reg_rdata <= data_q;
               `FCW_REG_RDAT: reg_rdata <= rdat_q;
               `FCW_REG_STAT: begin
                  reg_rdata[`FCW_STAT_BUSY] <= busy;
                  reg_rdata[`FCW_STAT_RB] <= ready_busy_n;
                  reg_rdata[`FCW_STAT_DONE] <= done_q;
                  reg_rdata[`FCW_STAT_SUSP] <= susp_q;
                  reg_rdata[`FCW_STAT_REFUSED] <= refused_q;
               end
               `FCW_REG_CTRL: begin
                  reg_rdata[`FCW_CTRL_OP_MSB:`FCW_CTRL_OP_LSB] <= op_q;
                  reg_rdata[`FCW_CTRL_PWRDN] <= pwrdn_q;
                  reg_rdata[`FCW_CTRL_HV] <= hv_override;
               end
               default: reg_rdata <= 8'h00;
            endcase
         end
         if (reg_wr && reg_addr == `FCW_REG_ADDR && !busy)
            addr_q <= {reg_wdata[3:0], {`FCW_BLK_LSB{1'b0}}} | (addr_q & {{4{1'b0}}, {`FCW_BLK_LSB{1'b1}}});
         if (reg_wr && reg_addr == `FCW_REG_DATA && !busy)
            data_q <= reg_wdata;
         if (reg_wr && reg_addr == `FCW_REG_RDAT && !busy)
            addr_q[7:0] <= reg_wdata;
         if (reg_wr && reg_addr == `FCW_REG_STAT) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
         end
         if (reg_wr && reg_addr == `FCW_REG_CTRL) begin
            pwrdn_q <= reg_wdata[`FCW_CTRL_PWRDN];
            hv_override <= reg_wdata[`FCW_CTRL_HV];
         end
         case (state_q)
            S_IDLE: begin
               chip_select_n <= 1'b1;
               output_enable_n <= 1'b1;
               // power-down forces the device pin low
               if (pwrdn_q) begin
                  reset_powerdown_n <= 1'b0;
                  susp_q <= 1'b0;
                  state_q <= S_WAKE;
                  cnt_q <= 16'h0000;
               end else if (go) begin
                  if (!supply_ok || !may_go) begin
                     refused_q <= 1'b1;
                  end else begin
                     op_q <= op_w;
                     second_q <= 1'b0;
                     done_q <= 1'b0;
                     if (op_w == `FCW_OP_RESUME)
                        susp_q <= 1'b0;
                     if (op_w == `FCW_OP_READ) begin
                        flash_addr <= addr_q;
                        chip_select_n <= 1'b0;
                        output_enable_n <= 1'b0;
                        state_q <= S_RDLOW;
                        cnt_q <= 16'h0000;
                     end else begin
                        state_q <= S_LOW;
                        cnt_q <= 16'h0000;
                     end
                  end
               end
            end
            S_LOW: begin
               chip_select_n <= 1'b0;
               write_strobe_n <= 1'b0;
               flash_addr <= cyc_addr;
               flash_dq_out <= cyc_data;
               flash_dq_oe <= 1'b1;
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == `FCW_WE_LOW_CYC) begin
                  // rising strobe latches address and data
                  write_strobe_n <= 1'b1;
                  cnt_q <= 16'h0000;
                  state_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == `FCW_WE_HIGH_CYC) begin
                  flash_dq_oe <= 1'b0;
                  chip_select_n <= 1'b1;
                  cnt_q <= 16'h0000;
                  if (two_cycle && !second_q) begin
                     second_q <= 1'b1;
                     state_q <= S_LOW;
                  end else if (op_q == `FCW_OP_SUSPEND) begin
                     state_q <= S_WAIT;
                  end else begin
                     state_q <= S_WAIT;
                  end
               end
            end
            S_WAIT: begin
               // busy while ready_busy_n low; ends wait
               if (ready_busy_n) begin
                  done_q <= 1'b1;
                  susp_q <= (op_q == `FCW_OP_SUSPEND);
                  state_q <= S_IDLE;
               end else if (go && may_go && supply_ok) begin
                  // suspend an erase; suspend a write
                  op_q <= `FCW_OP_SUSPEND;
                  second_q <= 1'b0;
                  cnt_q <= 16'h0000;
                  state_q <= S_LOW;
               end
            end
            S_RDLOW: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == `FCW_WE_LOW_CYC) begin
                  rdat_q <= flash_dq_in;
                  chip_select_n <= 1'b1;
                  output_enable_n <= 1'b1;
                  done_q <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_WAKE: begin
               if (pwrdn_q) begin
                  reset_powerdown_n <= 1'b0;
                  cnt_q <= 16'h0000;
               end else begin
                  reset_powerdown_n <= 1'b1;
                  cnt_q <= cnt_q + 16'h0001;
                  if (cnt_q == WAKE_CYC[15:0])
                     state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

endmodule

/* File: include/fcw_map.vh */
/*
 Constants for the flash command controller: host register offsets,
 field positions, flash command codes and pin timing counts.
 Assumes a 100 MHz core_clk.
*/
`ifndef FCW_MAP_VH
`define FCW_MAP_VH

// ----------------------------------------
// Host register offsets
// ----------------------------------------
`define FCW_REG_CTRL 4'h0
`define FCW_REG_ADDR 4'h1
`define FCW_REG_DATA 4'h2
`define FCW_REG_STAT 4'h3
`define FCW_REG_RDAT 4'h4

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FCW_CTRL_OP_LSB 0
`define FCW_CTRL_OP_MSB 2
`define FCW_CTRL_GO 3
`define FCW_CTRL_PWRDN 4
`define FCW_CTRL_HV 5

// ----------------------------------------
// Operation codes written to the control register
// ----------------------------------------
`define FCW_OP_READ 3'h0
`define FCW_OP_ERASE 3'h1
`define FCW_OP_WRITE 3'h2
`define FCW_OP_SETLOCK 3'h3
`define FCW_OP_SETMASTER 3'h4
`define FCW_OP_CLRLOCK 3'h5
`define FCW_OP_SUSPEND 3'h6
`define FCW_OP_RESUME 3'h7

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FCW_STAT_BUSY 0
`define FCW_STAT_RB 1
`define FCW_STAT_DONE 2
`define FCW_STAT_SUSP 3
`define FCW_STAT_REFUSED 4

// ----------------------------------------
// Flash command codes (the core uses these directly; it has no parameters for them)
// ----------------------------------------
`define FCW_CMD_READ 8'hFF
`define FCW_CMD_ERASE1 8'h20
`define FCW_CMD_CONFIRM 8'hD0
`define FCW_CMD_WRITE 8'h40
`define FCW_CMD_LOCK 8'h60
`define FCW_CMD_SETLOCK 8'h01
`define FCW_CMD_SETMASTER 8'hF1
`define FCW_CMD_SUSPEND 8'hB0

// ----------------------------------------
// Pin timing, in ns and cycles
// ----------------------------------------
`define FCW_CLK_NS 10
`define FCW_WE_LOW_NS 50
`define FCW_WE_HIGH_NS 30
`define FCW_WAKE_NS 1000
`define FCW_WE_LOW_CYC ((`FCW_WE_LOW_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WE_HIGH_CYC ((`FCW_WE_HIGH_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_WAKE_CYC ((`FCW_WAKE_NS + `FCW_CLK_NS - 1) / `FCW_CLK_NS)
`define FCW_ADDR_W 20
`define FCW_BLK_LSB 16

`endif

/* File: tb/fcw_flash_model.sv */
/* Behavioural flash device facing fcw_host.
   Assumes pins move on core_clk; unselected data reads the inverse byte. */
`timescale 1ns/1ps
`include "fcw_map.vh"
module fcw_flash_model (
   input wire core_clk,
   input wire [19:0] flash_addr,
   input wire [7:0] flash_dq_out,
   input wire chip_select_n,
   input wire output_enable_n,
   input wire write_strobe_n,
   input wire reset_powerdown_n,
   input wire hv_override,
   output logic [7:0] flash_dq_in,
   output wire ready_busy_n
);
   logic [7:0] mem [int];
   logic [15:0] lock_q = 16'h0000;
   logic master_q = 1'b0;
   logic susp_q = 1'b0;
   logic ws_q = 1'b1;
   logic [7:0] first_q = 8'h00;
   logic [7:0] rd_val;
   int busy_q = 0;
   wire [3:0] blk = flash_addr[19:16];
   assign ready_busy_n = busy_q == 0 || susp_q || !reset_powerdown_n;
   always @* begin
      rd_val = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
      flash_dq_in = (!chip_select_n && !output_enable_n) ? rd_val : ~rd_val;
   end
   always @(posedge core_clk) begin
      ws_q <= write_strobe_n;
      if (!reset_powerdown_n) begin
         busy_q <= 0;
         susp_q <= 1'b0;
         first_q <= 8'h00;
      end else if (write_strobe_n && !ws_q) begin
         if (first_q == 8'h00) begin
            if (flash_dq_out == `FCW_CMD_SUSPEND && busy_q != 0) susp_q <= 1'b1;
            else if (flash_dq_out == `FCW_CMD_CONFIRM) susp_q <= 1'b0;
            else if (flash_dq_out != `FCW_CMD_READ) first_q <= flash_dq_out;
         end else begin
            first_q <= 8'h00;
            busy_q <= first_q == `FCW_CMD_ERASE1 ? 40 : 6;
            if (first_q == `FCW_CMD_ERASE1 && (!lock_q[blk] || hv_override))
               for (int k = 0; k < 65536; k++) mem.delete({blk, k[15:0]});
            else if (first_q == `FCW_CMD_WRITE && (!lock_q[blk] || hv_override))
               mem[flash_addr] = rd_val & flash_dq_out;
            else if (first_q == `FCW_CMD_LOCK && (!master_q || hv_override)) begin
               if (flash_dq_out == `FCW_CMD_SETLOCK) lock_q[blk] <= 1'b1;
               if (flash_dq_out == `FCW_CMD_CONFIRM) lock_q <= 16'h0000;
               if (flash_dq_out == `FCW_CMD_SETMASTER && hv_override) master_q <= 1'b1;
            end
         end
      end else if (busy_q != 0 && !susp_q) busy_q <= busy_q - 1;
   end
endmodule

/* File: tb/fcw_host_assertions.sv */
/* Strobe, select and power-down pin checker for fcw_host; the register port is not checked.
   Assumes one core_clk domain and the pin counts of fcw_map.vh. */
`timescale 1ns/1ps
module fcw_host_assertions #(parameter ADDR_W = 20, parameter WAKE_CYC = 2) (
   input wire core_clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire [ADDR_W-1:0] flash_addr,
   input wire [7:0] flash_dq_in,
   input wire [7:0] flash_dq_out,
   input wire flash_dq_oe,
   input wire chip_select_n,
   input wire output_enable_n,
   input wire write_strobe_n,
   input wire reset_powerdown_n,
   input wire hv_override,
   input wire ready_busy_n,
   input wire supply_ok
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Strobe and data pins
   // ----------------------------------------
   chk_ws_cs: assert property (!write_strobe_n |-> !chip_select_n)
      else $error("strobe without select");
   chk_ws_drive: assert property (!write_strobe_n |-> flash_dq_oe)
      else $error("strobe without data drive");
   chk_dq_clash: assert property (flash_dq_oe |-> output_enable_n)
      else $error("data driven while output on");
   chk_latch_hold: assert property (!write_strobe_n |=> $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved at latch");
   chk_ws_low: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5])
      else $error("strobe low too short");
   chk_ws_high: assert property ($rose(write_strobe_n) |-> write_strobe_n [*3])
      else $error("strobe high too short");
   chk_pd_nowr: assert property (!reset_powerdown_n |-> write_strobe_n && chip_select_n)
      else $error("write during power-down");
   chk_wake_gap: assert property ($rose(reset_powerdown_n) |-> write_strobe_n [*3])
      else $error("write inside wake time");
   cov_strobe: cover property ($fell(write_strobe_n));
   cov_busy: cover property ($fell(ready_busy_n));
   cov_wake: cover property ($rose(reset_powerdown_n));
endmodule

bind fcw_host fcw_host_assertions #(.ADDR_W(ADDR_W), .WAKE_CYC(WAKE_CYC)) fcw_host_assertions_inst (
   .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .chip_select_n(chip_select_n),
   .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
   .reset_powerdown_n(reset_powerdown_n), .hv_override(hv_override), .ready_busy_n(ready_busy_n),
   .supply_ok(supply_ok));

/* File: tb/tb_fcw_host.sv */
/* Self-checking bench for fcw_host against the flash model.
   Assumes WAKE_CYC of 2 and the register layout of fcw_map.vh. */
`timescale 1ns/1ps
`include "fcw_map.vh"
module tb_fcw_host;
   logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, supply_ok = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, flash_dq_in, flash_dq_out, v;
   logic [19:0] flash_addr;
   logic flash_dq_oe, chip_select_n, output_enable_n, write_strobe_n, reset_powerdown_n, hv_override, ready_busy_n;
   int errors = 0, check_count = 0;
   always #5 core_clk = ~core_clk;
   fcw_host #(.WAKE_CYC(2)) fcw_host_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
      .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .reset_powerdown_n(reset_powerdown_n), .hv_override(hv_override), .ready_busy_n(ready_busy_n),
      .supply_ok(supply_ok));
   fcw_flash_model fcw_flash_model_inst (.core_clk(core_clk), .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
      .write_strobe_n(write_strobe_n), .reset_powerdown_n(reset_powerdown_n), .hv_override(hv_override),
      .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic poll(input int b, input logic val);
      int n = 0;
      do begin
         rd(`FCW_REG_STAT);
         n++;
      end while (v[b] !== val && n < 200);
      chk("poll", {7'h00, val}, {7'h00, v[b]});
   endtask
   task automatic go(input logic [7:0] ctl);
      wr(`FCW_REG_STAT, 8'h00);
      wr(`FCW_REG_CTRL, ctl | 8'h08);
   endtask
   task automatic op(input logic [7:0] ctl);
      go(ctl);
      poll(`FCW_STAT_DONE, 1'b1);
   endtask
   task automatic at(input logic [7:0] b, input logic [7:0] lo);
      wr(`FCW_REG_ADDR, b);
      wr(`FCW_REG_RDAT, lo);
   endtask
   task automatic put(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] d, input logic [7:0] hv);
      at(b, lo);
      wr(`FCW_REG_DATA, d);
      op(hv | `FCW_OP_WRITE);
   endtask
   task automatic get(input string name, input logic [7:0] b, input logic [7:0] lo, input logic [7:0] exp);
      at(b, lo);
      op(`FCW_OP_READ);
      rd(`FCW_REG_RDAT);
      chk(name, exp, v);
   endtask
   initial begin
      #500000;
      errors++;
      results;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd(`FCW_REG_STAT);
      chk("stat_idle", 8'h02, v & 8'h07);
      chk("pd_pin", 8'h01, {7'h00, reset_powerdown_n});
      put(3, 8'h12, 8'h5a, 0);
      put(4, 8'h12, 8'ha5, 0);
      get("byte", 3, 8'h12, 8'h5a);
      at(3, 0);
      op(`FCW_OP_ERASE);
      get("erased", 3, 8'h12, 8'hff);
      get("other", 4, 8'h12, 8'ha5);
      $display("write and erase done");
      at(4, 0);
      op(`FCW_OP_SETLOCK);
      put(4, 8'h12, 8'h00, 0);
      get("locked", 4, 8'h12, 8'ha5);
      put(4, 8'h12, 8'h00, 8'h20);
      get("override", 4, 8'h12, 8'h00);
      op(`FCW_OP_CLRLOCK);
      put(4, 8'h13, 8'h3c, 0);
      get("cleared", 4, 8'h13, 8'h3c);
      $display("locks done");
      at(5, 0);
      go(`FCW_OP_ERASE);
      poll(`FCW_STAT_RB, 1'b0);
      go(`FCW_OP_SUSPEND);
      poll(`FCW_STAT_SUSP, 1'b1);
      chk("susp_ready", 8'h02, v & 8'h02);
      op(`FCW_OP_RESUME);
      $display("suspend done");
      @(posedge core_clk);
      supply_ok <= 1'b0;
      go(`FCW_OP_WRITE);
      rd(`FCW_REG_STAT);
      chk("refused", 8'h10, v & 8'h10);
      @(posedge core_clk);
      supply_ok <= 1'b1;
      wr(`FCW_REG_STAT, 8'h00);
      rd(`FCW_REG_STAT);
      chk("ref_clear", 8'h00, v & 8'h10);
      wr(`FCW_REG_CTRL, 8'h10);
      rd(`FCW_REG_STAT);
      chk("pd_low", 8'h00, {7'h00, reset_powerdown_n});
      wr(`FCW_REG_CTRL, 8'h00);
      repeat (6) @(posedge core_clk);
      get("wake_read", 4, 8'h13, 8'h3c);
      rd(`FCW_REG_DATA);
      chk("data_reg", 8'h3c, v);
      rd(`FCW_REG_ADDR);
      chk("addr_reg", 8'h04, v);
      $display("supply and power-down done");
      op(`FCW_OP_SETMASTER | 8'h20);
      at(4, 8'h14);
      op(`FCW_OP_SETLOCK);
      rd(`FCW_REG_CTRL);
      chk("ctrl_reg", 8'h03, v & 8'h37);
      put(4, 8'h14, 8'h11, 0);
      get("master", 4, 8'h14, 8'h11);
      $display("master lock done");
      results;
   end
endmodule
